// File: include/clsr_pkg.sv
// Notes on behaviour
// - speed field 15:14, 10=1000, 01=100, 00=10; resets 10, kept on soft reset.
// - speed, duplex, pause, crossover meaningful only while resolved flag is one.
// - resolved flag set on negotiation complete, forced one while negotiation disabled.
// - duplex bit one for full, zero for half; resets zero, kept on soft reset.
// - page-received bit latches high on a page, clears when register is read.
// - real-time link bit follows present link state without latching.
// - pause bits mirror pause resolution; the block takes no action on them.
// - crossover bit one for MDIX, zero for MDI, resets one; manual mode shows setting.
// - new crossover mode setting takes effect only after a software reset.
// - energy-detect bit one while sleeping, zero while active.
// - global link bit one while link up, zero down; resets zero.
// - polarity bit one when reversed receive polarity detected, else zero.
// - polarity reversal suppressible in 10BASE-T only; gigabit per-pair polarity in separate four-bit field.
// - jabber bit one while jabber present, zero otherwise.
// - crossover mode 00 manual MDI, 01 manual MDIX, 11 automatic, 10 reserved.
// - with reversal disabled, 10BASE-T polarity is forced normal.
package clsr_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int PAIR_W = 4;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT = 5'h11;
    localparam logic [ADDR_W-1:0] OFS_IMASK = 5'h12;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 5'h13;
    localparam logic [ADDR_W-1:0] OFS_PAIR = 5'h15;

    // status register bit positions
    localparam int B_SPEED = 14;
    localparam int B_DUPLEX = 13;
    localparam int B_PAGE = 12;
    localparam int B_RESOLVED = 11;
    localparam int B_LINK_RT = 10;
    localparam int B_TXP = 9;
    localparam int B_RXP = 8;
    localparam int B_RSVD7 = 7;
    localparam int B_MDIX = 6;
    localparam int B_RSVD5 = 5;
    localparam int B_ENERGY = 4;
    localparam int B_GLINK = 3;
    localparam int B_RSVD2 = 2;
    localparam int B_POL = 1;
    localparam int B_JAB = 0;

    // control register bit positions
    localparam int C_SOFT_RST = 15;
    localparam int C_AN_EN = 12;
    localparam int C_XMODE = 5;
    localparam int C_POL_DIS = 1;

    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] XM_MDI = 2'h0;
    localparam logic [1:0] XM_MDIX = 2'h1;
    localparam logic [1:0] XM_AUTO = 2'h3;

    localparam logic [1:0] SPEED_RST = 2'h2;
    localparam logic [1:0] XMODE_RST = 2'h3;
    localparam logic MDIX_RST = 1'h1;
    localparam logic AN_EN_RST = 1'h1;

    // interrupt bits share the status layout: 12,11,10,6,4,1,0
    localparam logic [DATA_W-1:0] IRQ_VALID = 16'h1c53;
endpackage

// File: design/clsr_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module clsr_top (
    input wire logic ref_clk_i, // 250 MHz clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic [clsr_pkg::ADDR_W-1:0] addr_i, // register address
    input wire logic [clsr_pkg::DATA_W-1:0] wr_data_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [1:0] speed_i, // negotiated speed code
    input wire logic duplex_i, // negotiated duplex, 1 = full
    input wire logic pause_tx_i, // pause resolution, transmit
    input wire logic pause_rx_i, // pause resolution, receive
    input wire logic an_done_i, // negotiation complete level
    input wire logic page_rx_i, // page received pulse
    input wire logic link_rt_i, // real-time link level
    input wire logic link_up_i, // global link level
    input wire logic mdix_auto_i, // auto crossover result, 1 = MDIX
    input wire logic ed_sleep_i, // energy detect in sleep
    input wire logic pol_rev_i, // reversed polarity detected
    input wire logic [clsr_pkg::PAIR_W-1:0] pair_pol_i, // per-pair polarity, gigabit
    input wire logic jabber_i, // jabber condition present
    output logic [clsr_pkg::DATA_W-1:0] rd_data_o, // read data, cycle after strobe
    output logic irq_o, // level interrupt
    output logic an_enable_o, // negotiation enable
    output logic [1:0] xmode_o, // active crossover mode
    output logic pol_dis_o, // polarity reversal disabled
    output logic soft_rst_o // software reset pulse
);
    import clsr_pkg::*;

    typedef struct packed {
        logic [1:0] speed;
        logic duplex;
        logic page;
        logic resolved;
        logic link_rt;
        logic txp;
        logic rxp;
        logic mdix;
        logic energy;
        logic glink;
        logic pol;
        logic jab;
        logic [PAIR_W-1:0] pair_pol;
        logic an_en;
        logic [1:0] xmode_wr;
        logic [1:0] xmode;
        logic pol_dis;
        logic soft_rst;
        logic [DATA_W-1:0] imask;
        logic [DATA_W-1:0] istat;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } clsr_state_t;

    clsr_state_t st;
    clsr_state_t next_st;
    logic res_now;
    logic stat_rd;
    logic ten;
    logic gig;
    logic [DATA_W-1:0] stat_v;
    logic [DATA_W-1:0] ctrl_v;
    logic [DATA_W-1:0] ev;
    logic [DATA_W-1:0] w1c;

    assign rd_data_o = st.rdata;
    assign irq_o = st.irq;
    assign an_enable_o = st.an_en;
    assign xmode_o = st.xmode;
    assign pol_dis_o = st.pol_dis;
    assign soft_rst_o = st.soft_rst;

    always_comb begin
        next_st = st;
        ev = '0;
        w1c = '0;
        stat_v = '0;
        ctrl_v = '0;
        next_st.soft_rst = 1'h0;
        stat_rd = rd_i && (addr_i == OFS_STAT);
        ten = (st.speed == SPD_10);
        gig = (st.speed == SPD_1000);
        res_now = an_done_i | ~st.an_en;

        // live levels, no latching
        next_st.resolved = res_now;
        next_st.link_rt = link_rt_i;
        next_st.glink = link_up_i;
        next_st.energy = ed_sleep_i;
        next_st.jab = jabber_i;
        // suppressed in gigabit, where pairs report separately
        next_st.pol = pol_rev_i & ~gig & ~(st.pol_dis & ten);
        next_st.pair_pol = gig ? pair_pol_i : '0;

        // resolved results captured only while resolution holds
        if (res_now) begin
            next_st.speed = speed_i;
            next_st.duplex = duplex_i;
            next_st.txp = pause_tx_i;
            next_st.rxp = pause_rx_i;
        end

        // crossover status follows the active mode
        case (st.xmode)
            XM_MDI: begin
                next_st.mdix = 1'h0;
            end
            XM_MDIX: begin
                next_st.mdix = 1'h1;
            end
            default: begin
                if (res_now) begin
                    next_st.mdix = mdix_auto_i;
                end
            end
        endcase

        // set beats the clear of a read
        next_st.page = page_rx_i | (st.page & ~stat_rd);

        // software reset loads the pending crossover mode
        if (st.soft_rst) begin
            next_st.xmode = st.xmode_wr;
            next_st.page = page_rx_i;
        end

        // interrupt events
        ev[B_PAGE] = page_rx_i;
        ev[B_RESOLVED] = res_now & ~st.resolved;
        ev[B_LINK_RT] = link_rt_i ^ st.link_rt;
        ev[B_MDIX] = next_st.mdix ^ st.mdix;
        ev[B_ENERGY] = ed_sleep_i ^ st.energy;
        ev[B_POL] = next_st.pol ^ st.pol;
        ev[B_JAB] = jabber_i & ~st.jab;

        if (wr_i) begin
            case (addr_i)
                OFS_CTRL: begin
                    next_st.soft_rst = wr_data_i[C_SOFT_RST];
                    next_st.an_en = wr_data_i[C_AN_EN];
                    next_st.xmode_wr = wr_data_i[C_XMODE +: 2];
                    next_st.pol_dis = wr_data_i[C_POL_DIS];
                end
                OFS_IMASK: begin
                    next_st.imask = wr_data_i & IRQ_VALID;
                end
                OFS_ISTAT: begin
                    w1c = wr_data_i & IRQ_VALID;
                end
                default: begin
                    // status and pair registers ignore writes
                    w1c = '0;
                end
            endcase
        end
        next_st.istat = (st.istat & ~w1c) | (ev & IRQ_VALID);
        next_st.irq = |(next_st.istat & next_st.imask);

        // reserved positions stay zero
        stat_v[B_SPEED +: 2] = st.speed;
        stat_v[B_DUPLEX] = st.duplex;
        stat_v[B_PAGE] = st.page;
        stat_v[B_RESOLVED] = st.resolved;
        stat_v[B_LINK_RT] = st.link_rt;
        stat_v[B_TXP] = st.txp;
        stat_v[B_RXP] = st.rxp;
        stat_v[B_MDIX] = st.mdix;
        stat_v[B_ENERGY] = st.energy;
        stat_v[B_GLINK] = st.glink;
        stat_v[B_POL] = st.pol;
        stat_v[B_JAB] = st.jab;

        ctrl_v[C_AN_EN] = st.an_en;
        ctrl_v[C_XMODE +: 2] = st.xmode_wr;
        ctrl_v[C_POL_DIS] = st.pol_dis;

        next_st.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                OFS_CTRL: begin
                    next_st.rdata = ctrl_v;
                end
                OFS_STAT: begin
                    next_st.rdata = stat_v;
                end
                OFS_IMASK: begin
                    next_st.rdata = st.imask;
                end
                OFS_ISTAT: begin
                    next_st.rdata = st.istat;
                end
                OFS_PAIR: begin
                    next_st.rdata = {{(DATA_W-PAIR_W){1'h0}}, st.pair_pol};
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.speed <= SPEED_RST;
            st.mdix <= MDIX_RST;
            st.xmode <= XMODE_RST;
            st.xmode_wr <= XMODE_RST;
            st.an_en <= AN_EN_RST;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_stat_rd;
        rd_i && (addr_i == OFS_STAT);
    endsequence

    sequence s_ctrl_wr;
        wr_i && (addr_i == OFS_CTRL);
    endsequence

    property p_page_set;
        page_rx_i |=> st.page ##1 (st.page || $past(stat_rd) || $past(st.soft_rst));
    endproperty
    a_page_set: assert property (p_page_set) else $error("page flag not latched");

    property p_page_clr;
        (s_stat_rd and (st.page && !page_rx_i)) |=> !st.page && rd_data_o[B_PAGE];
    endproperty
    a_page_clr: assert property (p_page_clr) else $error("page flag not cleared by read");

    property p_page_hold;
        (st.page && !stat_rd && !st.soft_rst) |=> st.page;
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page flag lost without read");

    property p_resolved;
        (!st.an_en || an_done_i) |=> st.resolved;
    endproperty
    a_resolved: assert property (p_resolved) else $error("resolved flag missing");

    property p_speed_frozen;
        !res_now |=> (st.speed == $past(st.speed)) && (st.duplex == $past(st.duplex));
    endproperty
    a_speed_frozen: assert property (p_speed_frozen) else $error("speed changed while unresolved");

    property p_xmode_wait;
        s_ctrl_wr ##1 !st.soft_rst |=> st.xmode == $past(st.xmode);
    endproperty
    a_xmode_wait: assert property (p_xmode_wait) else $error("crossover mode changed without reset");

    property p_mdix_manual;
        (st.xmode == XM_MDIX) ##1 (st.xmode == XM_MDIX) |-> st.mdix;
    endproperty
    a_mdix_manual: assert property (p_mdix_manual) else $error("manual MDIX not shown");

    property p_pol_ten;
        (st.pol_dis && ten) |=> !st.pol;
    endproperty
    a_pol_ten: assert property (p_pol_ten) else $error("polarity not forced normal");

    property p_stat_read;
        s_stat_rd |=> (rd_data_o[B_RSVD7] == 1'h0) && (rd_data_o[B_RSVD5] == 1'h0)
            && (rd_data_o[B_RSVD2] == 1'h0) && (rd_data_o[B_GLINK] == $past(st.glink));
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");

    property p_live;
        1'h1 |=> (st.link_rt == $past(link_rt_i)) && (st.jab == $past(jabber_i))
            && (st.energy == $past(ed_sleep_i));
    endproperty
    a_live: assert property (p_live) else $error("live bit not following");

    property p_xmode_load;
        st.soft_rst |=> st.xmode == $past(st.xmode_wr);
    endproperty
    a_xmode_load: assert property (p_xmode_load) else $error("pending crossover mode not loaded");

    property p_speed_track;
        res_now |=> (st.speed == $past(speed_i)) && (st.duplex == $past(duplex_i));
    endproperty
    a_speed_track: assert property (p_speed_track) else $error("speed or duplex not captured");

    property p_pause;
        res_now |=> (st.txp == $past(pause_tx_i)) && (st.rxp == $past(pause_rx_i));
    endproperty
    a_pause: assert property (p_pause) else $error("pause result not mirrored");

    property p_mdix_mdi;
        (st.xmode == XM_MDI) ##1 (st.xmode == XM_MDI) |-> !st.mdix;
    endproperty
    a_mdix_mdi: assert property (p_mdix_mdi) else $error("manual MDI not shown");

    property p_glink;
        1'h1 |=> st.glink == $past(link_up_i);
    endproperty
    a_glink: assert property (p_glink) else $error("global link not following");

    property p_pol_gig;
        gig |=> !st.pol;
    endproperty
    a_pol_gig: assert property (p_pol_gig) else $error("polarity bit set in gigabit");

    property p_irq;
        irq_o == |(st.istat & st.imask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output mismatch");
endmodule

// File: sim/clsr_link_partner.sv
`timescale 1ns/1ps
module clsr_link_partner (
    input wire logic clk_i, // bench clock
    output logic [1:0] speed_o = 2'h0, // resolved speed
    output logic duplex_o = 1'h0, // resolved duplex
    output logic ptx_o = 1'h0, // transmit pause result
    output logic prx_o = 1'h0, // receive pause result
    output logic an_done_o = 1'h0, // negotiation finished
    output logic page_o = 1'h0, // page arrival pulse
    output logic link_rt_o = 1'h0, // present link level
    output logic link_up_o = 1'h0, // global link level
    output logic mdix_o = 1'h0, // auto crossover outcome
    output logic sleep_o = 1'h0, // energy detect asleep
    output logic pol_o = 1'h0, // reversed polarity seen
    output logic [3:0] pair_o = 4'h0, // per-pair polarity
    output logic jab_o = 1'h0 // jabber present
);
    // whole negotiated outcome changes in one cycle, as after a completed exchange
    task automatic bring_up(input logic [1:0] spd);
        @(posedge clk_i);
        speed_o <= spd;
        duplex_o <= 1'h1;
        {ptx_o, prx_o} <= 2'h3;
        an_done_o <= 1'h1;
        {link_rt_o, link_up_o} <= 2'h3;
        {sleep_o, pol_o, jab_o} <= 3'h7;
        pair_o <= 4'h5;
    endtask
    task automatic page_pulse();
        @(posedge clk_i);
        page_o <= 1'h1;
        @(posedge clk_i);
        page_o <= 1'h0;
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import clsr_pkg::*;
    logic ref_clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wr_data_i = '0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [DATA_W-1:0] rd_data_o, rd_val;
    logic irq_o, an_enable_o, pol_dis_o, soft_rst_o;
    logic [1:0] xmode_o;
    logic [1:0] spd;
    logic dup, ptx, prx, and_, pg, lrt, lup, mdx, slp, pol, jab;
    logic [3:0] pp;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] xctl [3] = '{16'h9020, 16'h9000, 16'h9060};
    logic [15:0] xexp [3] = '{16'h0040, 16'h0000, 16'h0040};
    always #2 ref_clk_i = ~ref_clk_i;
    clsr_link_partner lp (.clk_i(ref_clk_i), .speed_o(spd), .duplex_o(dup), .ptx_o(ptx), .prx_o(prx),
        .an_done_o(and_), .page_o(pg), .link_rt_o(lrt), .link_up_o(lup), .mdix_o(mdx), .sleep_o(slp),
        .pol_o(pol), .pair_o(pp), .jab_o(jab));
    clsr_top dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .speed_i(spd), .duplex_i(dup), .pause_tx_i(ptx), .pause_rx_i(prx),
        .an_done_i(and_), .page_rx_i(pg), .link_rt_i(lrt), .link_up_i(lup), .mdix_auto_i(mdx),
        .ed_sleep_i(slp), .pol_rev_i(pol), .pair_pol_i(pp), .jabber_i(jab), .rd_data_o(rd_data_o),
        .irq_o(irq_o), .an_enable_o(an_enable_o), .xmode_o(xmode_o), .pol_dis_o(pol_dis_o),
        .soft_rst_o(soft_rst_o));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'h0;
        #1 rd_val = rd_data_o;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        idle(20);
        sys_rst_i <= 1'h0;
        rd(OFS_STAT);
        chk(rd_val, 16'h8040);
        $display("reset values done");
        lp.bring_up(SPD_100);
        idle(3);
        rd(OFS_STAT);
        chk(rd_val, 16'h6f1b);
        $display("resolved status done");
        lp.page_pulse();
        idle(2);
        rd(OFS_STAT);
        chk(rd_val, 16'h7f1b);
        rd(OFS_STAT);
        chk(rd_val, 16'h6f1b);
        wr(OFS_STAT, 16'hffff);
        rd(OFS_STAT);
        chk(rd_val, 16'h6f1b);
        rd(5'h1f);
        chk(rd_val, 16'h0000);
        $display("page and write protect done");
        wr(OFS_CTRL, 16'h1020);
        idle(4);
        rd(OFS_STAT);
        chk(rd_val & 16'h0040, 16'h0000);
        chk({14'h0, xmode_o}, {14'h0, XM_AUTO});
        chk({15'h0, an_enable_o}, 16'h0001);
        rd(OFS_CTRL);
        chk(rd_val, 16'h1020);
        lp.mdix_o <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL, xctl[i]);
            #1 chk({15'h0, soft_rst_o}, 16'h0001);
            idle(4);
            rd(OFS_STAT);
            chk(rd_val & 16'h0040, xexp[i]);
            chk({14'h0, xmode_o}, {14'h0, xctl[i][6:5]});
            chk({15'h0, soft_rst_o}, 16'h0000);
        end
        $display("crossover done");
        chk({15'h0, irq_o}, 16'h0001 & 16'h0000);
        lp.page_pulse();
        wr(OFS_IMASK, 16'h1000);
        idle(2);
        chk({15'h0, irq_o}, 16'h0001);
        rd(OFS_IMASK);
        chk(rd_val, 16'h1000);
        rd(OFS_ISTAT);
        chk(rd_val & 16'h1000, 16'h1000);
        wr(OFS_ISTAT, 16'h1000);
        idle(2);
        chk({15'h0, irq_o}, 16'h0000);
        rd(OFS_ISTAT);
        chk(rd_val & 16'h1000, 16'h0000);
        $display("interrupt done");
        wr(OFS_CTRL, 16'h1062);
        lp.speed_o <= SPD_10;
        idle(4);
        rd(OFS_STAT);
        chk(rd_val & 16'hc002, 16'h0000);
        chk({15'h0, pol_dis_o}, 16'h0001);
        lp.speed_o <= SPD_100;
        idle(4);
        rd(OFS_STAT);
        chk(rd_val & 16'hc002, 16'h4002);
        lp.speed_o <= SPD_1000;
        idle(4);
        rd(OFS_PAIR);
        chk(rd_val, 16'h0005);
        rd(OFS_STAT);
        chk(rd_val & 16'hc002, 16'h8000);
        lp.an_done_o <= 1'h0;
        wr(OFS_CTRL, 16'h0060);
        idle(4);
        rd(OFS_STAT);
        chk(rd_val & 16'h0800, 16'h0800);
        chk({15'h0, an_enable_o}, 16'h0000);
        $display("polarity and resolve done");
        tally_and_finish();
    end
endmodule
